// [rtl/urcd_decoder.sv]
// command decoder for one uhf rfid channel: process output image in, job out
// assumes image bytes are synchronous and updated by img_valid_i pulses
`timescale 1ns/1ps
`include "urcd_params.svh"

module urcd_decoder
  import urcd_pkg::*;
(
  input wire logic sys_clk_i, // 250 MHz clock
  input wire logic rst_n_i, // synchronous reset, active low
  input wire logic img_valid_i, // pulse: a new image has arrived
  input wire logic [7:0] ctrl_byte_i, // byte 0, command bits
  input wire logic [7:0] cfg_byte_i, // byte 1, bank and length
  input wire logic [7:0] start_address_high_i, // byte 2
  input wire logic [7:0] start_address_low_i, // byte 3
  input wire logic tag_present_i, // a tag lies in the sensing range
  input wire logic tag_changed_i, // pulse: a different tag came into range
  input wire logic [7:0] tag_blocks_m1_i, // tag block count minus one
  input wire logic [7:0] tag_block_bytes_m1_i, // tag bytes per block minus one
  input wire logic job_done_i, // pulse: head logic finished the job
  input wire logic job_err_i, // with job_done_i: job failed
  input wire logic [15:0] job_err_code_i, // with job_err_i: error code
  output logic head_on_o, // head transmitter active
  output logic job_start_o, // pulse: start job on head
  output urcd_op_type job_op_o, // operation of current job
  output urcd_bank_type job_bank_o, // bank of current job
  output logic [3:0] job_len_o, // byte count, 1..8
  output logic [15:0] job_addr_o, // start address on tag
  output logic busy_o, // command executing or blocked
  output logic done_o, // last command finished
  output logic error_o, // error status
  output logic [15:0] err_code_o, // two error code bytes
  output logic info_valid_o, // geometry bytes valid
  output logic [63:0] info_data_o // geometry read data, byte 0 in bits 7:0
);
  typedef struct packed {
    urcd_fsm_type fsm;
    logic [7:0] prev;
    logic blocked;
    logic used;
    logic head;
    logic start;
    urcd_op_type op;
    urcd_bank_type bank;
    logic [3:0] len;
    logic [15:0] addr;
    logic done;
    logic err;
    logic [15:0] code;
    logic info_v;
    logic [63:0] info;
  } urcd_state_type;

  urcd_state_type state_q, state_d;
  logic [7:0] rise;
  logic [2:0] ncmd;
  logic multi;
  urcd_op_type new_op;

  always_comb begin
    rise = ctrl_byte_i & ~state_q.prev;
    ncmd = 3'({2'h0, ctrl_byte_i[`URCD_B_UID]}) + 3'({2'h0, ctrl_byte_i[`URCD_B_READ]})
         + 3'({2'h0, ctrl_byte_i[`URCD_B_WRITE]}) + 3'({2'h0, ctrl_byte_i[`URCD_B_GEOM]})
         + 3'({2'h0, ctrl_byte_i[`URCD_B_HINFO]});
    multi = (ncmd > 3'h1);
    new_op = URCD_OP_NONE;
    if (rise[`URCD_B_UID]) begin
      new_op = URCD_OP_UID;
    end else if (rise[`URCD_B_READ]) begin
      new_op = URCD_OP_READ;
    end else if (rise[`URCD_B_WRITE]) begin
      new_op = URCD_OP_WRITE;
    end else if (rise[`URCD_B_GEOM]) begin
      new_op = URCD_OP_GEOM;
    end else if (rise[`URCD_B_HINFO]) begin
      new_op = URCD_OP_HINFO;
    end
  end

  always_comb begin
    state_d = state_q;
    state_d.start = 1'b0;
    if (tag_changed_i) begin
      state_d.used = 1'b0;
    end
    case (state_q.fsm)
      URCD_IDLE: begin
        if (state_q.blocked && tag_changed_i) begin
          state_d.blocked = 1'b0;
        end
        if (img_valid_i && !state_q.blocked && new_op != URCD_OP_NONE) begin
          if (multi) begin
            state_d.err = 1'b1;
          end else if (ctrl_byte_i[`URCD_B_NEXT] && state_q.used && !tag_changed_i) begin
            state_d.blocked = 1'b1;
            state_d.done = 1'b0;
          end else if (ctrl_byte_i[`URCD_B_HEAD] && tag_present_i) begin
            state_d.fsm = URCD_BUSY;
            state_d.start = (new_op != URCD_OP_GEOM);
            state_d.op = new_op;
            state_d.bank = urcd_bank_type'(cfg_byte_i[`URCD_BANK_HI:`URCD_BANK_LO]);
            state_d.len = {1'b0, cfg_byte_i[`URCD_LEN_HI:0]} + 4'h1;
            state_d.addr = {start_address_high_i, start_address_low_i};
            state_d.done = 1'b0;
            state_d.info_v = 1'b0;
          end
        end
      end
      URCD_BUSY: begin
        if (state_q.op == URCD_OP_GEOM) begin
          // geometry answered locally: blocks-1, bytes-1, then six zero bytes
          state_d.info = {48'h0, tag_block_bytes_m1_i, tag_blocks_m1_i};
          state_d.info_v = 1'b1;
          state_d.fsm = URCD_IDLE;
          state_d.done = 1'b1;
          state_d.used = 1'b1;
        end else if (job_done_i) begin
          state_d.fsm = URCD_IDLE;
          state_d.done = 1'b1;
          state_d.used = 1'b1;
          if (job_err_i) begin
            state_d.err = 1'b1;
            state_d.code = job_err_code_i;
          end
        end
      end
      default: state_d.fsm = URCD_IDLE;
    endcase
    // flagged at every image, busy or not; the reset bit below still wins
    if (img_valid_i && multi) begin
      state_d.err = 1'b1;
    end
    if (img_valid_i && rise[`URCD_B_RESET]) begin
      state_d.fsm = URCD_IDLE;
      state_d.start = 1'b0;
      state_d.blocked = 1'b0;
      state_d.used = 1'b0;
      state_d.done = 1'b1;
      state_d.err = 1'b0;
      state_d.code = 16'h0000;
    end
    if (img_valid_i) begin
      state_d.prev = ctrl_byte_i;
    end
    // enable from the latest image only, the byte lines are not valid in between;
    // head stays lit while busy even if enable drops, off once done
    state_d.head = state_d.prev[`URCD_B_HEAD] || (state_d.fsm == URCD_BUSY);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign head_on_o = state_q.head;
  assign job_start_o = state_q.start;
  assign job_op_o = state_q.op;
  assign job_bank_o = state_q.bank;
  assign job_len_o = state_q.len;
  assign job_addr_o = state_q.addr;
  assign busy_o = (state_q.fsm == URCD_BUSY) || state_q.blocked;
  assign done_o = state_q.done;
  assign error_o = state_q.err;
  assign err_code_o = state_q.code;
  assign info_valid_o = state_q.info_v;
  assign info_data_o = state_q.info;

  a_multi_error: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_valid_i && multi && !rise[`URCD_B_RESET] |=> error_o)
    else $error("several command bits set without error");
  a_head_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    busy_o && !state_q.blocked |-> head_on_o || $past(!busy_o))
    else $error("head off while command in progress");
  a_head_follow: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(img_valid_i) && !busy_o && !$past(busy_o)
      |-> head_on_o == $past(ctrl_byte_i[`URCD_B_HEAD]))
    else $error("head does not follow enable");
  a_head_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !$past(img_valid_i) && !busy_o && !$past(busy_o) |-> head_on_o == $past(head_on_o))
    else $error("head changed between images");
  a_reset_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_valid_i && rise[`URCD_B_RESET] |=> done_o && !error_o && err_code_o == 16'h0000
      && !busy_o)
    else $error("reset bit did not abort and clear");
  a_len_code: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    job_start_o |-> job_len_o == {1'b0, $past(cfg_byte_i[`URCD_LEN_HI:0])} + 4'h1)
    else $error("job length not count plus one");
  a_bank_take: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    job_start_o |-> job_bank_o == $past(cfg_byte_i[`URCD_BANK_HI:`URCD_BANK_LO]))
    else $error("bank select not taken");
  a_held_bit: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_valid_i && ctrl_byte_i == state_q.prev ##1 1'b1 |-> !job_start_o)
    else $error("held command bit restarted");
  a_read_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    img_valid_i && !busy_o && !multi && rise[`URCD_B_READ] && !rise[`URCD_B_UID]
      && ctrl_byte_i[`URCD_B_HEAD] && tag_present_i && !rise[`URCD_B_RESET]
      && !(ctrl_byte_i[`URCD_B_NEXT] && state_q.used)
      |=> job_start_o && job_op_o == URCD_OP_READ)
    else $error("read edge did not start a read");
  a_geom_data: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(info_valid_o) |-> info_data_o[63:16] == 48'h0)
    else $error("geometry tail bytes not zero");
  a_once_tag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state_q.blocked && !tag_changed_i && !(img_valid_i && rise[`URCD_B_RESET])
      |=> busy_o)
    else $error("blocked command released early");
endmodule

// [rtl/urcd_params.svh]
// constants of the uhf rfid command decoder: bit positions and field layout
// assumes the process output image arrives as separate bytes per update
`ifndef URCD_PARAMS_SVH
`define URCD_PARAMS_SVH
`define URCD_B_HEAD 7
`define URCD_B_NEXT 6
`define URCD_B_UID 5
`define URCD_B_READ 4
`define URCD_B_WRITE 3
`define URCD_B_GEOM 2
`define URCD_B_HINFO 1
`define URCD_B_RESET 0
`define URCD_BANK_HI 5
`define URCD_BANK_LO 4
`define URCD_LEN_HI 2
`define URCD_BANK_RSV 2'h0
`define URCD_BANK_UII 2'h1
`define URCD_BANK_TID 2'h2
`define URCD_BANK_USR 2'h3
`define URCD_INFO_BYTES 4'h8
`endif

// [rtl/urcd_pkg.sv]
// types of the uhf rfid command decoder
// shared by the single design module
package urcd_pkg;
  typedef enum logic [2:0] {
    URCD_OP_NONE, URCD_OP_UID, URCD_OP_READ, URCD_OP_WRITE, URCD_OP_GEOM, URCD_OP_HINFO
  } urcd_op_type;
  typedef enum logic [1:0] {
    URCD_BANK_RESERVED, URCD_BANK_IDENT, URCD_BANK_TAGID, URCD_BANK_USER
  } urcd_bank_type;
  typedef enum {URCD_IDLE, URCD_BUSY} urcd_fsm_type;
endpackage

// [bench/urcd_head_model.sv]
// head logic stand-in: answers each job start with a done pulse
// assumes job_start_i is the decoder's one-cycle launch pulse
`timescale 1ns/1ps
module urcd_head_model (
  input wire logic sys_clk_i, // clock
  input wire logic rst_n_i, // sync reset, active low
  input wire logic job_start_i, // job launch pulse
  input wire logic [3:0] delay_i, // cycles to done, 1..15
  input wire logic fail_i, // report the job as failed
  output logic job_done_o, // done pulse
  output logic job_err_o, // failed, with done
  output logic [15:0] job_err_code_o // code, valid with done only
);
  localparam logic [15:0] ERR_CODE = 16'hA5C3; // arbitrary value
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      job_done_o <= 1'b0;
      job_err_o <= 1'b0;
      job_err_code_o <= 16'h0000;
    end else begin
      cnt_q <= job_start_i ? delay_i : (cnt_q != 4'h0 ? cnt_q - 4'h1 : 4'h0);
      job_done_o <= (cnt_q == 4'h1);
      job_err_o <= (cnt_q == 4'h1) & fail_i;
      // toggles outside done so a stale code shows the valid value only every other cycle
      job_err_code_o <= (cnt_q == 4'h1) ? ERR_CODE : ~job_err_code_o;
    end
  end
endmodule

// [bench/urcd_decoder_bench.sv]
// bench for the command decoder: images in, job and status checked
// assumes the head model answers every job start
`timescale 1ns/1ps
module urcd_decoder_bench;
  import urcd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, img_valid = 1'b0, tag_chg = 1'b0, fail = 1'b0;
  logic tag_in = 1'b1;
  logic [7:0] ctrl = 8'h00, cfg = 8'h00, a_hi = 8'h00, a_lo = 8'h00;
  logic [3:0] delay = 4'h3;
  logic dn_p, er_p, head_on, start, busy, done, error, info_v;
  logic [15:0] ec_p, addr, ecode;
  urcd_op_type op;
  urcd_bank_type bank;
  logic [3:0] len;
  logic [63:0] info;
  int num_errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  urcd_decoder u_urcd_decoder (.sys_clk_i(clk), .rst_n_i(rst_n), .img_valid_i(img_valid),
    .ctrl_byte_i(ctrl), .cfg_byte_i(cfg), .start_address_high_i(a_hi),
    .start_address_low_i(a_lo), .tag_present_i(tag_in), .tag_changed_i(tag_chg),
    .tag_blocks_m1_i(8'h1B), .tag_block_bytes_m1_i(8'h03), .job_done_i(dn_p),
    .job_err_i(er_p), .job_err_code_i(ec_p), .head_on_o(head_on), .job_start_o(start),
    .job_op_o(op), .job_bank_o(bank), .job_len_o(len), .job_addr_o(addr), .busy_o(busy),
    .done_o(done), .error_o(error), .err_code_o(ecode), .info_valid_o(info_v),
    .info_data_o(info));
  urcd_head_model u_urcd_head_model (.sys_clk_i(clk), .rst_n_i(rst_n), .job_start_i(start),
    .delay_i(delay), .fail_i(fail), .job_done_o(dn_p), .job_err_o(er_p),
    .job_err_code_o(ec_p));
  task automatic print_verdict();
    $display("checked %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one image; returns just after the edge that takes it
  task automatic send(input logic [7:0] c, input logic [7:0] g, input logic [15:0] a);
    @(posedge clk);
    ctrl <= c;
    cfg <= g;
    {a_hi, a_lo} <= a;
    img_valid <= 1'b1;
    @(posedge clk);
    img_valid <= 1'b0;
    #1;
  endtask
  // one-cycle new-tag pulse, driven like an image
  task automatic pulse_tag();
    @(posedge clk);
    tag_chg <= 1'b1;
    @(posedge clk);
    tag_chg <= 1'b0;
    #1;
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 40 && busy === 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 40) begin
      num_errors++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check({head_on, busy, done, error}, 4'h0);
    send(8'h80, 8'h37, 16'h1234);
    check(head_on, 1'b1);
    send(8'h90, 8'h37, 16'h1234);
    check({start, op, bank, len, addr}, {1'b1, URCD_OP_READ, URCD_BANK_USER, 4'h8, 16'h1234});
    wait_idle();
    check({busy, done}, 2'b01);
    send(8'h90, 8'h37, 16'h1234);
    check(start, 1'b0);
    for (int b = 0; b < 4; b++) begin
      send(8'h80, 8'h00, 16'h0000);
      send(8'h90, {2'b00, 2'(b), 1'b0, 3'(b * 2 + 1)}, 16'h0010);
      check({bank, len}, {2'(b), 4'(b * 2 + 2)});
      wait_idle();
    end
    send(8'h80, 8'h00, 16'h0000);
    send(8'hA0, 8'h00, 16'h0000);
    check({start, op}, {1'b1, URCD_OP_UID});
    wait_idle();
    @(posedge clk);
    tag_in <= 1'b0;
    send(8'h80, 8'h00, 16'h0000);
    send(8'hA0, 8'h00, 16'h0000);
    check({start, busy}, 2'b00);
    @(posedge clk);
    tag_in <= 1'b1;
    fail <= 1'b1;
    send(8'h80, 8'h32, 16'h0040);
    send(8'h88, 8'h32, 16'h0040);
    check({start, op, bank, len, addr}, {1'b1, URCD_OP_WRITE, URCD_BANK_USER, 4'h3, 16'h0040});
    wait_idle();
    check({error, ecode}, {1'b1, 16'hA5C3});
    fail <= 1'b0;
    delay <= 4'hF;
    send(8'h80, 8'h37, 16'h0000);
    send(8'h90, 8'h37, 16'h0000);
    send(8'h81, 8'h37, 16'h0000);
    check({busy, done, error, ecode}, {3'b010, 16'h0000});
    repeat (16) @(posedge clk);
    send(8'h80, 8'h00, 16'h0000);
    send(8'hB0, 8'h00, 16'h0000);
    check({error, start}, 2'b10);
    send(8'h80, 8'h00, 16'h0000);
    send(8'h84, 8'h00, 16'h0000);
    @(posedge clk);
    #1;
    check(info_v, 1'b1);
    check(info, 64'h031B);
    send(8'h80, 8'h00, 16'h0000);
    send(8'h82, 8'h00, 16'h00F0);
    check({start, op, addr}, {1'b1, URCD_OP_HINFO, 16'h00F0});
    wait_idle();
    delay <= 4'h8;
    send(8'h80, 8'h00, 16'h0000);
    send(8'h90, 8'h37, 16'h0000);
    send(8'h00, 8'h37, 16'h0000);
    check(head_on, 1'b1);
    wait_idle();
    @(posedge clk);
    #1;
    check(head_on, 1'b0);
    pulse_tag();
    send(8'hC0, 8'h37, 16'h0000);
    send(8'hD0, 8'h37, 16'h0000);
    wait_idle();
    send(8'hC0, 8'h37, 16'h0000);
    send(8'hD0, 8'h37, 16'h0000);
    check({start, busy}, 2'b01);
    pulse_tag();
    check(busy, 1'b0);
    print_verdict();
  end
endmodule
